// ### agen_pkg.sv
// Package for the operand and jump address generator.
// Assumes an 8-bit data path, a 15-bit program counter and
// synchronous program and data memories answering one cycle after a read.
package agen_pkg;

   // Register offsets in data memory
   localparam logic [7:0] PSW_OFF = 8'hEF;    // Status word
   localparam logic [7:0] XP_OFF  = 8'hFC;    // Second pointer
   localparam logic [7:0] SP_OFF  = 8'hFD;    // Stack pointer
   localparam logic [7:0] BP_OFF  = 8'hFE;    // First pointer
   localparam logic [7:0] SEG_OFF = 8'hFF;    // Segment select

   // Address decode limits
   localparam logic [7:0]  ONES_LO = 8'h70;     // All-ones hole start
   localparam logic [7:0]  ONES_HI = 8'h7F;     // All-ones hole end
   localparam logic [15:0] RAM2_LO = 16'h0100;  // Upper RAM block start
   localparam logic [15:0] RAM2_HI = 16'h013F;  // Upper RAM block end
   localparam logic [7:0]  ALL_ONES = 8'hFF;    // Value of the hole

   // Status word field positions
   localparam int PSW_C_BIT   = 7;             // Carry
   localparam int PSW_HC_BIT  = 6;             // Half carry
   localparam int PSW_GIE_BIT = 0;             // Global interrupt enable

   // Reset values
   localparam logic [7:0]  PSW_RST = 8'h00;    // Flags clear
   localparam logic [7:0]  PTR_RST = 8'h00;    // Pointers
   localparam logic [7:0]  SP_RST  = 8'h6F;    // Top of low RAM
   localparam logic [7:0]  SEG_RST = 8'h00;    // Segment zero
   localparam logic [14:0] PC_RST  = 15'h0000; // Program start

   // Addressing modes: six operand, four transfer, plus vector fetch
   typedef enum logic [3:0] {
      M_PTR       = 4'h0,   // Pointer indirect
      M_PTR_UPD   = 4'h1,   // Pointer indirect, post update
      M_DIRECT    = 4'h2,   // Direct 8-bit address
      M_IMM       = 4'h3,   // 8-bit immediate
      M_SHORT_IMM = 4'h4,   // 4-bit immediate into first pointer
      M_TABLE     = 4'h5,   // Table read from program memory
      M_REL       = 4'h6,   // Relative jump
      M_ABS       = 4'h7,   // Short absolute jump or call
      M_ABS_LONG  = 4'h8,   // Long absolute jump or call
      M_IND_JUMP  = 4'h9,   // Indirect jump
      M_VIS       = 4'hA    // Vector to service routine
   } mode_t;

   // Sequencer states
   typedef enum logic [2:0] {
      S_IDLE   = 3'h0,      // Waiting for a request
      S_ISSUE  = 3'h1,      // Memory strobe out
      S_CAPT   = 3'h2,      // Memory data in
      S_VISSUE = 3'h3,      // Second vector byte strobe out
      S_VCAPT  = 3'h4       // Second vector byte in
   } state_t;

   // One decoded request from the core
   typedef struct packed {
      mode_t       mode;      // Addressing mode
      logic        write;     // Data operand is written, not read
      logic        dec;       // Post decrement instead of increment
      logic        xsel;      // Use second pointer
      logic [7:0]  field8;    // Direct address, immediate or jump offset
      logic [14:0] field15;   // Absolute jump field
      logic [7:0]  wdata;     // Write data
   } req_t;

endpackage

// ### agen.sv
// Operand and jump address generator for an 8-bit core.
// Assumes the core issues one request at a time while busy is low, and
// that both memories return read data on the cycle after the strobe.
`timescale 1ns/1ps

module agen (
   input  wire logic           clk,                   // 100 MHz clock
   input  wire logic           rstn,                  // Async reset, low
   input  wire logic           req_valid,             // Request strobe
   input  wire agen_pkg::req_t req,                   // Decoded request
   input  wire logic [7:0]     acc,                   // Accumulator
   input  wire logic [14:0]    vec_addr,              // Vector location
   input  wire logic           pc_step,               // Advance PC by one
   output logic                busy,                  // Sequencer active
   output logic                done,                  // Request finished
   output logic [7:0]          operand,               // Operand value
   output logic                pm_rd,                 // Program read
   output logic [14:0]         pm_addr,               // Program address
   input  wire logic [7:0]     pm_rdata,              // Program data
   output logic                dm_rd,                 // Data read
   output logic                dm_we,                 // Data write
   output logic [15:0]         dm_addr,               // Data address
   output logic [7:0]          dm_wdata,              // Data write value
   input  wire logic [7:0]     dm_rdata,              // Data read value
   output logic                ram_hi_sel,            // Upper RAM selected
   output logic [14:0]         program_counter,       // Program counter
   output logic [7:0]          first_data_pointer,    // First pointer
   output logic [7:0]          second_data_pointer,   // Second pointer
   output logic [7:0]          stack_pointer,         // Stack pointer
   output logic [7:0]          segment_select,        // Segment register
   output logic                carry_flag,            // Carry
   output logic                nibble_overflow_flag,  // Half carry
   output logic                global_irq_enable      // Interrupt enable
);

   // Architectural state
   logic [14:0]      pc_q, pc_d;          // Program counter
   logic [7:0]       b_q, b_d;            // First pointer
   logic [7:0]       x_q, x_d;            // Second pointer
   logic [7:0]       sp_q, sp_d;          // Stack pointer
   logic [7:0]       psw_q, psw_d;        // Status word
   logic [7:0]       seg_q, seg_d;        // Segment select

   // Sequencer state
   agen_pkg::state_t st_q, st_d;          // Current step
   agen_pkg::req_t   cur_q, cur_d;        // Request in flight
   logic [7:0]       vu_q, vu_d;          // Upper vector byte held
   logic [7:0]       op_q, op_d;          // Operand result
   logic             done_q, done_d;      // Finish pulse

   // Memory strobes, all registered
   logic             pm_rd_q, pm_rd_d;        // Program read
   logic [14:0]      pm_addr_q, pm_addr_d;    // Program address
   logic             dm_rd_q, dm_rd_d;        // Data read
   logic             dm_we_q, dm_we_d;        // Data write
   logic [15:0]      dm_addr_q, dm_addr_d;    // Data address
   logic [7:0]       dm_wdata_q, dm_wdata_d;  // Data write value

   // Decode helpers
   logic             accept;              // Request taken this cycle
   logic [7:0]       a8;                  // Low data address for a request
   logic [7:0]       cap_a8;              // Low data address being answered
   logic             cap_seg0;            // Answer comes from segment zero
   logic [14:0]      rel_off;             // Sign-extended relative step
   logic [7:0]       field8_w;            // Request byte field, for checks
   logic             xsel_w;              // Request pointer choice, for checks

   assign accept   = (st_q == agen_pkg::S_IDLE) && req_valid;
   assign cap_a8   = dm_addr_q[7:0];
   assign cap_seg0 = (dm_addr_q[15:8] == 8'h00);
   assign field8_w = req.field8;
   assign xsel_w   = req.xsel;

   // True where an internal register answers instead of RAM
   function automatic logic reg_hit(input logic [7:0] a);
      reg_hit = (a == agen_pkg::PSW_OFF) || (a >= agen_pkg::XP_OFF);
   endfunction

   // Relative field f encodes an offset of f+1, so -31..+32 fits six bits
   always_comb begin
      rel_off = 15'(signed'(req.field8[5:0])) + 15'h0001;
   end

   // Address source for data operand modes
   always_comb begin
      if (req.mode == agen_pkg::M_DIRECT) begin
         a8 = req.field8;
      end else begin
         a8 = req.xsel ? x_q : b_q;
      end
   end

   // Next-state logic for sequencer, registers and strobes
   always_comb begin
      st_d       = st_q;
      cur_d      = cur_q;
      pc_d       = pc_q;
      b_d        = b_q;
      x_d        = x_q;
      sp_d       = sp_q;
      psw_d      = psw_q;
      seg_d      = seg_q;
      vu_d       = vu_q;
      op_d       = op_q;
      done_d     = 1'b0;
      pm_rd_d    = 1'b0;
      pm_addr_d  = pm_addr_q;
      dm_rd_d    = 1'b0;
      dm_we_d    = 1'b0;
      dm_addr_d  = dm_addr_q;
      dm_wdata_d = dm_wdata_q;
      // Plain sequential fetch; skips cost one step per byte from the core
      if (pc_step && st_q == agen_pkg::S_IDLE) begin
         pc_d = pc_q + 15'h0001;
      end
      unique case (st_q)
         agen_pkg::S_IDLE: begin
            if (req_valid) begin
               cur_d = req;
               unique case (req.mode)
                  agen_pkg::M_PTR, agen_pkg::M_PTR_UPD, agen_pkg::M_DIRECT: begin
                     dm_addr_d = {seg_q, a8};
                     // Register writes land now so a post update follows them
                     if (req.write && reg_hit(a8)) begin
                        unique case (a8)
                           agen_pkg::PSW_OFF: psw_d = req.wdata;
                           agen_pkg::XP_OFF:  x_d   = req.wdata;
                           agen_pkg::SP_OFF:  sp_d  = req.wdata;
                           agen_pkg::BP_OFF:  b_d   = req.wdata;
                           default:           seg_d = req.wdata;
                        endcase
                     end else if (req.write) begin
                        dm_we_d    = 1'b1;
                        dm_wdata_d = req.wdata;
                     end else if (!reg_hit(a8)) begin
                        dm_rd_d = 1'b1;
                     end
                     st_d = agen_pkg::S_ISSUE;
                  end
                  agen_pkg::M_IMM: begin
                     op_d   = req.field8;
                     done_d = 1'b1;
                  end
                  agen_pkg::M_SHORT_IMM: begin
                     b_d    = {4'h0, req.field8[3:0]};
                     op_d   = {4'h0, req.field8[3:0]};
                     done_d = 1'b1;
                  end
                  agen_pkg::M_TABLE, agen_pkg::M_IND_JUMP: begin
                     pm_rd_d   = 1'b1;
                     pm_addr_d = {pc_q[14:8], acc};
                     st_d      = agen_pkg::S_ISSUE;
                  end
                  agen_pkg::M_REL: begin
                     // Zero field is the plus-one case: same as a no-op step
                     if (req.field8[5:0] == 6'h00) begin
                        pc_d = pc_q + 15'h0001;
                     end else begin
                        pc_d = pc_q + rel_off;
                     end
                     done_d = 1'b1;
                  end
                  agen_pkg::M_ABS: begin
                     pc_d   = {pc_q[14:12], req.field15[11:0]};
                     done_d = 1'b1;
                  end
                  agen_pkg::M_ABS_LONG: begin
                     pc_d   = req.field15;
                     done_d = 1'b1;
                  end
                  agen_pkg::M_VIS: begin
                     pm_rd_d   = 1'b1;
                     pm_addr_d = vec_addr;
                     st_d      = agen_pkg::S_ISSUE;
                  end
                  default: begin
                     // Unused codes finish at once with no effect
                     done_d = 1'b1;
                  end
               endcase
            end
         end
         agen_pkg::S_ISSUE: begin
            st_d = agen_pkg::S_CAPT;
         end
         agen_pkg::S_CAPT: begin
            st_d   = agen_pkg::S_IDLE;
            done_d = 1'b1;
            unique case (cur_q.mode)
               agen_pkg::M_TABLE: begin
                  op_d = pm_rdata;
               end
               agen_pkg::M_IND_JUMP: begin
                  pc_d = {pc_q[14:8], pm_rdata};
               end
               agen_pkg::M_VIS: begin
                  vu_d      = pm_rdata;
                  pm_rd_d   = 1'b1;
                  pm_addr_d = pm_addr_q + 15'h0001;
                  st_d      = agen_pkg::S_VISSUE;
                  done_d    = 1'b0;
               end
               default: begin
                  // Data operand answer
                  if (cur_q.write) begin
                     op_d = cur_q.wdata;
                  end else if (reg_hit(cap_a8)) begin
                     unique case (cap_a8)
                        agen_pkg::PSW_OFF: op_d = psw_q;
                        agen_pkg::XP_OFF:  op_d = x_q;
                        agen_pkg::SP_OFF:  op_d = sp_q;
                        agen_pkg::BP_OFF:  op_d = b_q;
                        default:           op_d = seg_q;
                     endcase
                  end else if (cap_seg0 && cap_a8 >= agen_pkg::ONES_LO && cap_a8 <= agen_pkg::ONES_HI) begin
                     op_d = agen_pkg::ALL_ONES;
                  end else begin
                     op_d = dm_rdata;
                  end
                  // Post update after the access, wrapping in eight bits
                  if (cur_q.mode == agen_pkg::M_PTR_UPD) begin
                     if (cur_q.xsel) begin
                        x_d = cur_q.dec ? x_q - 8'h01 : x_q + 8'h01;
                     end else begin
                        b_d = cur_q.dec ? b_q - 8'h01 : b_q + 8'h01;
                     end
                  end
               end
            endcase
         end
         agen_pkg::S_VISSUE: begin
            st_d = agen_pkg::S_VCAPT;
         end
         agen_pkg::S_VCAPT: begin
            pc_d   = {vu_q[6:0], pm_rdata};
            st_d   = agen_pkg::S_IDLE;
            done_d = 1'b1;
         end
         default: begin
            st_d = agen_pkg::S_IDLE;
         end
      endcase
   end

   // State registers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_q       <= agen_pkg::S_IDLE;
         cur_q      <= '0;
         pc_q       <= agen_pkg::PC_RST;
         b_q        <= agen_pkg::PTR_RST;
         x_q        <= agen_pkg::PTR_RST;
         sp_q       <= agen_pkg::SP_RST;
         psw_q      <= agen_pkg::PSW_RST;
         seg_q      <= agen_pkg::SEG_RST;
         vu_q       <= 8'h00;
         op_q       <= 8'h00;
         done_q     <= 1'b0;
         pm_rd_q    <= 1'b0;
         pm_addr_q  <= 15'h0000;
         dm_rd_q    <= 1'b0;
         dm_we_q    <= 1'b0;
         dm_addr_q  <= 16'h0000;
         dm_wdata_q <= 8'h00;
      end else begin
         st_q       <= st_d;
         cur_q      <= cur_d;
         pc_q       <= pc_d;
         b_q        <= b_d;
         x_q        <= x_d;
         sp_q       <= sp_d;
         psw_q      <= psw_d;
         seg_q      <= seg_d;
         vu_q       <= vu_d;
         op_q       <= op_d;
         done_q     <= done_d;
         pm_rd_q    <= pm_rd_d;
         pm_addr_q  <= pm_addr_d;
         dm_rd_q    <= dm_rd_d;
         dm_we_q    <= dm_we_d;
         dm_addr_q  <= dm_addr_d;
         dm_wdata_q <= dm_wdata_d;
      end
   end

   // Outputs
   assign busy                 = (st_q != agen_pkg::S_IDLE);
   assign done                 = done_q;
   assign operand              = op_q;
   assign pm_rd                = pm_rd_q;
   assign pm_addr              = pm_addr_q;
   assign dm_rd                = dm_rd_q;
   assign dm_we                = dm_we_q;
   assign dm_addr              = dm_addr_q;
   assign dm_wdata             = dm_wdata_q;
   assign ram_hi_sel           = (dm_addr_q >= agen_pkg::RAM2_LO) && (dm_addr_q <= agen_pkg::RAM2_HI);
   assign program_counter      = pc_q;
   assign first_data_pointer   = b_q;
   assign second_data_pointer  = x_q;
   assign stack_pointer        = sp_q;
   assign segment_select       = seg_q;
   assign carry_flag           = psw_q[agen_pkg::PSW_C_BIT];
   assign nibble_overflow_flag = psw_q[agen_pkg::PSW_HC_BIT];
   assign global_irq_enable    = psw_q[agen_pkg::PSW_GIE_BIT];

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence vis_two_reads;
      pm_rd && pm_addr == $past(vec_addr) ##2 pm_rd && pm_addr == $past(pm_addr, 2) + 15'h0001;
   endsequence

   a_vis_fetch: assert property (accept && req.mode == agen_pkg::M_VIS |=> vis_two_reads ##2 done)
      else $error("vector fetch sequence wrong");
   a_ones_hole: assert property (st_q == agen_pkg::S_CAPT && cur_q.mode != agen_pkg::M_TABLE
      && cur_q.mode != agen_pkg::M_IND_JUMP && cur_q.mode != agen_pkg::M_VIS && !cur_q.write && cap_seg0
      && cap_a8 >= 8'h70 && cap_a8 <= 8'h7F |=> done && operand == 8'hFF)
      else $error("hole read not all ones");
   a_ptr_addr: assert property (accept && req.mode == agen_pkg::M_PTR
      |=> dm_addr[7:0] == ($past(xsel_w) ? $past(x_q) : $past(b_q)))
      else $error("pointer address wrong");
   a_post_inc: assert property (st_q == agen_pkg::S_CAPT && cur_q.mode == agen_pkg::M_PTR_UPD
      && !cur_q.xsel && !cur_q.dec |=> b_q == $past(b_q) + 8'h01)
      else $error("first pointer not incremented");
   a_direct_addr: assert property (accept && req.mode == agen_pkg::M_DIRECT
      |=> dm_addr[7:0] == $past(field8_w) ##2 done)
      else $error("direct address wrong");
   a_imm_value: assert property (accept && req.mode == agen_pkg::M_IMM
      |=> done && operand == $past(field8_w) && !dm_rd && !busy)
      else $error("immediate operand wrong");
   a_short_imm: assert property (accept && req.mode == agen_pkg::M_SHORT_IMM
      |=> b_q == {4'h0, $past(field8_w[3:0])})
      else $error("short immediate wrong");
   a_table_addr: assert property (accept && req.mode == agen_pkg::M_TABLE
      |=> pm_rd && pm_addr == {$past(pc_q[14:8]), $past(acc)} ##2 done && operand == $past(pm_rdata))
      else $error("table read wrong");
   a_abs_keep: assert property (accept && req.mode == agen_pkg::M_ABS
      |=> pc_q[14:12] == $past(pc_q[14:12]) && pc_q[11:0] == $past(req.field15[11:0]))
      else $error("short jump target wrong");
   a_rel_nop: assert property (accept && req.mode == agen_pkg::M_REL && req.field8[5:0] == 6'h00
      |=> pc_q == $past(pc_q) + 15'h0001)
      else $error("plus one jump not a step");

endmodule

// ### agen_tb_notes_none.sv
`timescale 1ns/1ps
// No logic here; the bench and its memory model stand in their own files

// ### mem_model.sv
// Behavioural program and data memory facing the address generator.
// Assumes both memories answer on the cycle after a read strobe.
`timescale 1ns/1ps
module mem_model (
   input  wire logic        clk,      // Core clock
   input  wire logic        pm_rd,    // Program read strobe
   input  wire logic [14:0] pm_addr,  // Program address
   output logic [7:0]       pm_rdata, // Program data
   input  wire logic        dm_rd,    // Data read strobe
   input  wire logic        dm_we,    // Data write strobe
   input  wire logic [15:0] dm_addr,  // Data address
   input  wire logic [7:0]  dm_wdata, // Data write value
   output logic [7:0]       dm_rdata  // Data read value
);
   logic [7:0] ram [512]; // Low and upper data RAM
   // Known pattern so the bench can predict every byte
   initial begin
      pm_rdata = 8'h00;
      dm_rdata = 8'h00;
      for (int i = 0; i < 512; i++) ram[i] = i[7:0] ^ 8'hA5;
   end
   // Outside a read the bus is scrambled, so stale data never passes
   always @(posedge clk) begin
      pm_rdata <= pm_rd ? (pm_addr[7:0] ^ {1'b0, pm_addr[14:8]}) : ~pm_rdata;
      dm_rdata <= dm_rd ? ram[dm_addr[8:0]] : ~dm_rdata;
      if (dm_we) ram[dm_addr[8:0]] <= dm_wdata;
   end
endmodule

// ### agen_tb_top.sv
// Self-checking bench for the address generator with its memories.
// Assumes one request at a time, driven on the falling edge.
`timescale 1ns/1ps
module agen_tb_top;
   logic clk = 1'b0, rstn, req_valid, pc_step, busy, done;
   logic pm_rd, dm_rd, dm_we, ram_hi_sel, carry_flag, nibble_overflow_flag, global_irq_enable;
   agen_pkg::req_t req;
   logic [7:0]  acc, operand, pm_rdata, dm_wdata, dm_rdata, first_data_pointer;
   logic [7:0]  second_data_pointer, stack_pointer, segment_select;
   logic [14:0] vec_addr, pm_addr, program_counter;
   logic [15:0] dm_addr;
   int          bad_count = 0, samples_checked = 0;
   always #5 clk = ~clk;
   agen i_dut (.clk(clk), .rstn(rstn), .req_valid(req_valid), .req(req), .acc(acc),
      .vec_addr(vec_addr), .pc_step(pc_step), .busy(busy), .done(done), .operand(operand),
      .pm_rd(pm_rd), .pm_addr(pm_addr), .pm_rdata(pm_rdata), .dm_rd(dm_rd), .dm_we(dm_we),
      .dm_addr(dm_addr), .dm_wdata(dm_wdata), .dm_rdata(dm_rdata), .ram_hi_sel(ram_hi_sel),
      .program_counter(program_counter), .first_data_pointer(first_data_pointer),
      .second_data_pointer(second_data_pointer), .stack_pointer(stack_pointer),
      .segment_select(segment_select), .carry_flag(carry_flag),
      .nibble_overflow_flag(nibble_overflow_flag), .global_irq_enable(global_irq_enable));
   mem_model i_mem (.clk(clk), .pm_rd(pm_rd), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
      .dm_rd(dm_rd), .dm_we(dm_we), .dm_addr(dm_addr), .dm_wdata(dm_wdata), .dm_rdata(dm_rdata));
   // Program byte pattern held by the memory model
   function automatic logic [7:0] pmv(logic [14:0] a);
      return a[7:0] ^ {1'b0, a[14:8]};
   endfunction
   // Compare one value
   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   // One request, then a bounded wait for done
   task automatic issue(agen_pkg::mode_t m, logic [7:0] f8, logic [14:0] f15, logic d, logic x,
                        logic w = 1'b0, logic [7:0] wd = 8'h00);
      int n;
      @(negedge clk);
      req = '{m, w, d, x, f8, f15, wd};
      req_valid = 1'b1;
      @(negedge clk);
      req_valid = 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 10) begin
         @(negedge clk);
         n++;
      end
      chk("done", 16'h0001, {15'h0, done});
      chk("idle", 16'h0000, {15'h0, busy});
   endtask
   // Register values straight after reset
   task automatic t_reset();
      chk("pc", 16'h0000, {1'b0, program_counter});
      chk("sp", 16'h006F, {8'h0, stack_pointer});
      chk("ptrs", 16'h0000, {first_data_pointer, second_data_pointer});
      chk("flags", 16'h0000, {13'h0, carry_flag, nibble_overflow_flag, global_irq_enable});
      $display("test reset finished");
   endtask
   // Direct, hole and immediate operands
   task automatic t_operand();
      issue(agen_pkg::M_DIRECT, 8'h40, 15'h0, 1'b0, 1'b0);
      chk("direct", 16'h00E5, {8'h0, operand});
      chk("daddr", 16'h0040, dm_addr);
      issue(agen_pkg::M_DIRECT, 8'h75, 15'h0, 1'b0, 1'b0);
      chk("hole", 16'h00FF, {8'h0, operand});
      issue(agen_pkg::M_IMM, 8'h3C, 15'h0, 1'b0, 1'b0);
      chk("imm", 16'h003C, {8'h0, operand});
      issue(agen_pkg::mode_t'(4'hB), 8'h55, 15'h0, 1'b0, 1'b0);
      chk("unused", 16'h003C, {8'h0, operand});
      $display("test operand finished");
   endtask
   // Register and RAM writes, then a read from the upper RAM segment
   task automatic t_write();
      issue(agen_pkg::M_DIRECT, 8'hEF, 15'h0, 1'b0, 1'b0, 1'b1, 8'hC1);
      chk("flagswr", 16'h0007, {13'h0, carry_flag, nibble_overflow_flag, global_irq_enable});
      issue(agen_pkg::M_DIRECT, 8'h50, 15'h0, 1'b0, 1'b0, 1'b1, 8'h3D);
      issue(agen_pkg::M_DIRECT, 8'h50, 15'h0, 1'b0, 1'b0);
      chk("wback", 16'h003D, {8'h0, operand});
      issue(agen_pkg::M_DIRECT, 8'hFD, 15'h0, 1'b0, 1'b0, 1'b1, 8'h4B);
      chk("spwr", 16'h004B, {8'h0, stack_pointer});
      issue(agen_pkg::M_DIRECT, 8'hFF, 15'h0, 1'b0, 1'b0, 1'b1, 8'h01);
      issue(agen_pkg::M_DIRECT, 8'h20, 15'h0, 1'b0, 1'b0);
      chk("hiram", 16'h0185, {7'h0, ram_hi_sel, operand});
      issue(agen_pkg::M_DIRECT, 8'hFF, 15'h0, 1'b0, 1'b0, 1'b1, 8'h00);
      chk("seg", 16'h0000, {8'h0, segment_select});
      $display("test write finished");
   endtask
   // Pointer modes with wrap in both directions
   task automatic t_pointer();
      issue(agen_pkg::M_PTR_UPD, 8'h00, 15'h0, 1'b1, 1'b1);
      chk("ind", 16'h00A5, {8'h0, operand});
      chk("xdec", 16'h00FF, {8'h0, second_data_pointer});
      issue(agen_pkg::M_PTR_UPD, 8'h00, 15'h0, 1'b0, 1'b1);
      chk("regread", 16'h0000, {8'h0, operand});
      chk("xinc", 16'h0000, {8'h0, second_data_pointer});
      issue(agen_pkg::M_SHORT_IMM, 8'h07, 15'h0, 1'b0, 1'b0);
      chk("bload", 16'h0007, {8'h0, first_data_pointer});
      issue(agen_pkg::M_PTR, 8'h00, 15'h0, 1'b0, 1'b0);
      chk("bind", 16'h00A2, {8'h0, operand});
      $display("test pointer finished");
   endtask
   // Relative, short and long absolute transfers
   task automatic t_jump();
      issue(agen_pkg::M_ABS_LONG, 8'h00, 15'h7FFF, 1'b0, 1'b0);
      chk("long", 16'h7FFF, {1'b0, program_counter});
      issue(agen_pkg::M_REL, 8'h01, 15'h0, 1'b0, 1'b0);
      chk("relwrap", 16'h0001, {1'b0, program_counter});
      issue(agen_pkg::M_REL, 8'h00, 15'h0, 1'b0, 1'b0);
      chk("relone", 16'h0002, {1'b0, program_counter});
      issue(agen_pkg::M_ABS_LONG, 8'h00, 15'h5123, 1'b0, 1'b0);
      issue(agen_pkg::M_ABS, 8'h00, 15'h0ABC, 1'b0, 1'b0);
      chk("short", 16'h5ABC, {1'b0, program_counter});
      issue(agen_pkg::M_REL, 8'h20, 15'h0, 1'b0, 1'b0);
      chk("relback", 16'h5A9D, {1'b0, program_counter});
      @(negedge clk) pc_step = 1'b1;
      repeat (3) @(negedge clk);
      pc_step = 1'b0;
      chk("step", 16'h5AA0, {1'b0, program_counter});
      $display("test jump finished");
   endtask
   // Program memory reads: table, indirect jump, vector
   task automatic t_rom();
      acc = 8'h34;
      vec_addr = 15'h0120;
      issue(agen_pkg::M_TABLE, 8'h00, 15'h0, 1'b0, 1'b0);
      chk("table", {8'h0, pmv(15'h5A34)}, {8'h0, operand});
      chk("paddr", 16'h5A34, {1'b0, pm_addr});
      issue(agen_pkg::M_IND_JUMP, 8'h00, 15'h0, 1'b0, 1'b0);
      chk("jind", {1'b0, 7'h5A, pmv(15'h5A34)}, {1'b0, program_counter});
      issue(agen_pkg::M_VIS, 8'h00, 15'h0, 1'b0, 1'b0);
      chk("vis", {pmv(15'h0120) & 8'h7F, pmv(15'h0121)}, {1'b0, program_counter});
      $display("test rom finished");
   endtask
   // Counts and verdict
   task automatic conclude();
      $display("checked %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Hang guard, far beyond the roughly ninety cycles needed
   initial begin
      #20000;
      bad_count++;
      conclude();
   end
   // Main sequence
   initial begin
      rstn = 1'b0;
      req_valid = 1'b0;
      req = '0;
      acc = 8'h00;
      vec_addr = 15'h0000;
      pc_step = 1'b0;
      repeat (4) @(posedge clk);
      @(negedge clk) rstn = 1'b1;
      t_reset();
      t_operand();
      t_write();
      t_pointer();
      t_jump();
      t_rom();
      conclude();
   end
endmodule
